//--- verilog/p3g_regs.svh
// Register offsets, field positions and reset values of the port block
`ifndef P3G_REGS_SVH
`define P3G_REGS_SVH

// Byte offsets on the register bus
`define P3G_OFS_DATA      8'h00
`define P3G_OFS_DIR       8'h04
`define P3G_OFS_PULLUP    8'h08
`define P3G_OFS_AIN_DIS   8'h0C
`define P3G_OFS_DATA_RMW  8'h10
`define P3G_OFS_CTRL      8'h14
`define P3G_OFS_PIN_RAW   8'h18

// Address bits that are decoded
`define P3G_ADDR_MSB      7

// Control register fields
`define P3G_CTRL_FLOAT    0
`define P3G_CTRL_A_AIDIS  1
`define P3G_CTRL_A_NSEL   2
`define P3G_CTRL_B_AIDIS  3
`define P3G_CTRL_B_NSEL   4
`define P3G_CTRL_WIDTH    5

// Reset values
`define P3G_RST_DATA      8'h00
`define P3G_RST_DIR       8'h00
`define P3G_RST_PULLUP    8'h00
`define P3G_RST_AIN_DIS   8'h00
`define P3G_RST_CTRL      5'h00

// Pin positions of the shared analog and comparator functions
`define P3G_PIN_A_NEG     0
`define P3G_PIN_A_POS     1
`define P3G_PIN_A_OUT     2
`define P3G_PIN_B_NEG     3
`define P3G_PIN_B_POS     4
`define P3G_PIN_B_OUT     5

`endif

//--- verilog/p3g_pkg.sv
// Types shared by the port block files
`default_nettype none
package p3g_pkg;

    typedef logic [7:0] p3g_byte_t;

    typedef enum logic [1:0] {
        P3G_RESP_OKAY   = 2'b00,
        P3G_RESP_SLVERR = 2'b10
    } p3g_resp_e;

endpackage

`default_nettype wire

//--- verilog/p3g_sync2.sv
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none

module p3g_sync2 #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Stage one feeds only stage two, to contain metastability
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- verilog/p3g_port.sv
// Eight-pin general-purpose port with analog and comparator sharing, AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "p3g_regs.svh"

module p3g_port #(
    parameter int PINS = 8
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Standby controller
    input  wire logic              stop_or_watch,
    // Pins
    input  wire logic [PINS-1:0]   pin_in,
    output logic      [PINS-1:0]   pin_out,
    output logic      [PINS-1:0]   pin_oe,
    output logic      [PINS-1:0]   pin_pullup_on,
    // Comparator digital outputs
    input  wire logic              cmp_a_out,
    input  wire logic              cmp_a_out_en,
    input  wire logic              cmp_b_out,
    input  wire logic              cmp_b_out_en,
    // Inputs toward on-chip peripherals
    output logic      [PINS-1:0]   periph_in,
    output logic      [PINS-1:0]   analog_in_en,
    output logic                   cmp_a_neg_in_en,
    output logic                   cmp_a_pos_in_en,
    output logic                   cmp_b_neg_in_en,
    output logic                   cmp_b_pos_in_en
);

    // Register state
    logic [PINS-1:0]              port_data_latch;
    logic [PINS-1:0]              port_direction;
    logic [PINS-1:0]              port_pullup_enable;
    logic [PINS-1:0]              analog_input_disable_low;
    logic [`P3G_CTRL_WIDTH-1:0]   ctrl;

    // Bus handshake state
    logic                         aw_held;
    logic                         w_held;
    logic [7:0]                   aw_addr;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;

    // Synchronised pin levels
    logic [PINS-1:0]              pin_sync;

    // Pin levels cross into aclk here; no logic reads pin_in itself
    p3g_sync2 #(
        .WIDTH (PINS)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // Control fields
    wire standby_pin_float     = ctrl[`P3G_CTRL_FLOAT];
    wire cmp_a_analog_in_dis   = ctrl[`P3G_CTRL_A_AIDIS];
    wire cmp_a_neg_source_sel  = ctrl[`P3G_CTRL_A_NSEL];
    wire cmp_b_analog_in_dis   = ctrl[`P3G_CTRL_B_AIDIS];
    wire cmp_b_neg_source_sel  = ctrl[`P3G_CTRL_B_NSEL];

    // Pins float only while standby is active and float is selected
    // Float overrides both the direction bit and any peripheral takeover
    wire pins_floated = standby_pin_float & stop_or_watch;

    // Peripheral output takeover per pin; only the comparator output pins have one
    logic [PINS-1:0] periph_oe;
    logic [PINS-1:0] periph_val;

    always_comb begin
        periph_oe                = '0;
        periph_val               = '0;
        periph_oe[`P3G_PIN_A_OUT]  = cmp_a_out_en;
        periph_val[`P3G_PIN_A_OUT] = cmp_a_out;
        periph_oe[`P3G_PIN_B_OUT]  = cmp_b_out_en;
        periph_val[`P3G_PIN_B_OUT] = cmp_b_out;
    end

    // Pin drive, bit n of each register steering pin n
    wire [PINS-1:0] drive_en  = periph_oe | port_direction;
    wire [PINS-1:0] drive_val = (periph_oe & periph_val) | (~periph_oe & port_data_latch);

    wire [PINS-1:0] next_pin_oe  = pins_floated ? '0 : drive_en;
    wire [PINS-1:0] next_pin_out = drive_val & next_pin_oe;
    // Pull-up drops out whenever the pin drives low; floated pins lose it too
    wire [PINS-1:0] next_pullup  = port_pullup_enable & ~(next_pin_oe & ~drive_val)
                                   & {PINS{~pins_floated}};

    // Digital input gate: analog disable must be set, and standby float blocks it low
    wire [PINS-1:0] digital_in_en = analog_input_disable_low & {PINS{~pins_floated}};
    wire [PINS-1:0] gated_in      = pin_sync & digital_in_en;

    wire [PINS-1:0] next_analog_en = ~analog_input_disable_low & {PINS{~pins_floated}};

    // Comparator input enables are independent of data latch and direction
    wire next_cmp_a_pos = ~cmp_a_analog_in_dis;
    wire next_cmp_b_pos = ~cmp_b_analog_in_dis;
    wire next_cmp_a_neg = ~cmp_a_analog_in_dis & ~cmp_a_neg_source_sel;
    wire next_cmp_b_neg = ~cmp_b_analog_in_dis & ~cmp_b_neg_source_sel;

    // Normal data read: latch for port outputs, gated pin level otherwise (0 while the digital input gate is shut).
    // A pin taken by a peripheral reads back from the pin even with its
    // direction bit set, so software sees what is really driven.
    wire [PINS-1:0] latch_view    = port_direction & ~periph_oe;
    wire [PINS-1:0] data_read_val = (latch_view & port_data_latch)
                                    | (~latch_view & gated_in);

    // Registered outputs toward pins and peripherals
    // Every pin-side output is a flop so pad timing does not depend on the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_oe          <= '0;
            pin_out         <= '0;
            pin_pullup_on   <= '0;
            periph_in       <= '0;
            analog_in_en    <= '0;
            cmp_a_pos_in_en <= 1'b0;
            cmp_b_pos_in_en <= 1'b0;
            cmp_a_neg_in_en <= 1'b0;
            cmp_b_neg_in_en <= 1'b0;
        end else begin
            pin_oe          <= next_pin_oe;
            pin_out         <= next_pin_out;
            pin_pullup_on   <= next_pullup;
            periph_in       <= gated_in;
            analog_in_en    <= next_analog_en;
            cmp_a_pos_in_en <= next_cmp_a_pos;
            cmp_b_pos_in_en <= next_cmp_b_pos;
            cmp_a_neg_in_en <= next_cmp_a_neg;
            cmp_b_neg_in_en <= next_cmp_b_neg;
        end
    end

    // Write channel: address and data taken in either order, response after both
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire do_write = aw_held & w_held;

    wire wr_data    = do_write & (aw_addr == `P3G_OFS_DATA);
    wire wr_dir     = do_write & (aw_addr == `P3G_OFS_DIR);
    wire wr_pullup  = do_write & (aw_addr == `P3G_OFS_PULLUP);
    wire wr_ain_dis = do_write & (aw_addr == `P3G_OFS_AIN_DIS);
    wire wr_rmw     = do_write & (aw_addr == `P3G_OFS_DATA_RMW);
    wire wr_ctrl    = do_write & (aw_addr == `P3G_OFS_CTRL);
    wire wr_raw     = do_write & (aw_addr == `P3G_OFS_PIN_RAW);
    wire wr_hit     = wr_data | wr_dir | wr_pullup | wr_ain_dis | wr_rmw | wr_ctrl | wr_raw;
    wire wr_lane0   = w_strb[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            aw_addr <= '0;
            w_data  <= '0;
            w_strb  <= '0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[`P3G_ADDR_MSB:2], 2'b00};
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= p3g_pkg::P3G_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            // Unmapped offsets answer SLVERR and change no register
            s_axi_bresp  <= wr_hit ? p3g_pkg::P3G_RESP_OKAY : p3g_pkg::P3G_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register writes; only byte lane 0 carries register bits
    // A write lands one edge after both channels are held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_data_latch          <= `P3G_RST_DATA;
            port_direction           <= `P3G_RST_DIR;
            port_pullup_enable       <= `P3G_RST_PULLUP;
            analog_input_disable_low <= `P3G_RST_AIN_DIS;
            ctrl                     <= `P3G_RST_CTRL;
        end else if (wr_lane0) begin
            // Both data views store into the latch whatever the pin direction
            if (wr_data | wr_rmw) begin
                port_data_latch <= w_data[PINS-1:0];
            end
            if (wr_dir) begin
                port_direction <= w_data[PINS-1:0];
            end
            if (wr_pullup) begin
                port_pullup_enable <= w_data[PINS-1:0];
            end
            if (wr_ain_dis) begin
                analog_input_disable_low <= w_data[PINS-1:0];
            end
            if (wr_ctrl) begin
                ctrl <= w_data[`P3G_CTRL_WIDTH-1:0];
            end
        end
    end

    // Read channel: one read at a time, data registered with its valid
    // Read data stays frozen while rvalid waits for rready
    assign s_axi_arready = ~s_axi_rvalid;

    wire       ar_take = s_axi_arvalid & s_axi_arready;
    // Only word addresses are decoded; the two low address bits are ignored
    wire [7:0] ar_addr = {s_axi_araddr[`P3G_ADDR_MSB:2], 2'b00};

    wire rd_data    = (ar_addr == `P3G_OFS_DATA);
    wire rd_dir     = (ar_addr == `P3G_OFS_DIR);
    wire rd_pullup  = (ar_addr == `P3G_OFS_PULLUP);
    wire rd_ain_dis = (ar_addr == `P3G_OFS_AIN_DIS);
    wire rd_rmw     = (ar_addr == `P3G_OFS_DATA_RMW);
    wire rd_ctrl    = (ar_addr == `P3G_OFS_CTRL);
    wire rd_raw     = (ar_addr == `P3G_OFS_PIN_RAW);
    wire rd_hit     = rd_data | rd_dir | rd_pullup | rd_ain_dis | rd_rmw | rd_ctrl | rd_raw;

    // The bus cannot mark a locked cycle, so the latch-returning view sits at its own offset
    wire [31:0] next_rdata =
          ({32{rd_data}}    & {{(32-PINS){1'b0}}, data_read_val})
        | ({32{rd_rmw}}     & {{(32-PINS){1'b0}}, port_data_latch})
        | ({32{rd_dir}}     & {{(32-PINS){1'b0}}, port_direction})
        | ({32{rd_pullup}}  & {{(32-PINS){1'b0}}, port_pullup_enable})
        | ({32{rd_ain_dis}} & {{(32-PINS){1'b0}}, analog_input_disable_low})
        | ({32{rd_ctrl}}    & {{(32-`P3G_CTRL_WIDTH){1'b0}}, ctrl})
        | ({32{rd_raw}}     & {{(32-PINS){1'b0}}, pin_sync});

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= p3g_pkg::P3G_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= rd_hit ? p3g_pkg::P3G_RESP_OKAY : p3g_pkg::P3G_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

`default_nettype wire

//--- dv/p3g_pin_model.sv
// Behavioural model of the board wiring around the port pins
`timescale 1ns/1ps
`default_nettype none

module p3g_pin_model (
    // Clock
    input  wire logic       aclk,
    // Device side
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pin_pullup_on,
    // Board drivers
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_in
);
    // Undriven pins wander every cycle so a stale level never passes for a real one
    logic [7:0] drift = 8'h00;

    always_ff @(posedge aclk) drift <= ~drift;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pullup_on[i]) pin_in[i] = 1'h1;
            else pin_in[i] = drift[i];
        end
    end
endmodule

`default_nettype wire

//--- dv/p3g_port_sva.sv
// Port-level assertions for the port block, with their bind
`timescale 1ns/1ps
`default_nettype none

module p3g_port_sva #(
    parameter int PINS = 8
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // Register bus
    input  wire logic            s_axi_awready,
    input  wire logic            s_axi_wready,
    input  wire logic [1:0]      s_axi_bresp,
    input  wire logic            s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic            s_axi_arvalid,
    input  wire logic            s_axi_arready,
    input  wire logic [31:0]     s_axi_rdata,
    input  wire logic            s_axi_rvalid,
    input  wire logic            s_axi_rready,
    // Pins and peripherals
    input  wire logic [PINS-1:0] pin_out,
    input  wire logic [PINS-1:0] pin_oe,
    input  wire logic [PINS-1:0] pin_pullup_on,
    input  wire logic [PINS-1:0] periph_in,
    input  wire logic [PINS-1:0] analog_in_en,
    input  wire logic            cmp_a_out,
    input  wire logic            cmp_a_out_en
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_reset_clear: assert property ($rose(aresetn) |-> pin_oe == '0 && analog_in_en == '0)
        else $error("pins not cleared by reset");
    a_pullup_low: assert property ((pin_pullup_on & pin_oe & ~pin_out) == '0)
        else $error("pull-up left on a pin driving low");
    a_gate_input: assert property ((periph_in & analog_in_en) == '0)
        else $error("digital input passed on an analog pin");
    a_cmp_drive: assert property ($past(cmp_a_out_en) && pin_oe[2] |-> pin_out[2] == $past(cmp_a_out))
        else $error("comparator output not on its pin");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_w_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_cmp_pin: cover property (cmp_a_out_en && pin_oe[2]);
endmodule

bind p3g_port p3g_port_sva #(
    .PINS (PINS)
) sva_i (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awready (s_axi_awready),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .pin_out       (pin_out),
    .pin_oe        (pin_oe),
    .pin_pullup_on (pin_pullup_on),
    .periph_in     (periph_in),
    .analog_in_en  (analog_in_en),
    .cmp_a_out     (cmp_a_out),
    .cmp_a_out_en  (cmp_a_out_en)
);

`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the port block
`timescale 1ns/1ps
`default_nettype none
`include "p3g_regs.svh"

module tb;
    logic aclk = 1'h0, aresetn = 1'h0, stop_or_watch = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic cmp_a_out = 1'h0, cmp_a_out_en = 1'h0, cmp_b_out = 1'h0, cmp_b_out_en = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata;
    logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_on, periph_in, analog_in_en;
    logic cmp_a_neg_in_en, cmp_a_pos_in_en, cmp_b_neg_in_en, cmp_b_pos_in_en;
    int error_cnt = 0;
    int checked = 0;

    p3g_port uut (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .s_axi_awaddr    (s_axi_awaddr),
        .s_axi_awvalid   (s_axi_awvalid),
        .s_axi_awready   (s_axi_awready),
        .s_axi_wdata     (s_axi_wdata),
        .s_axi_wstrb     (s_axi_wstrb),
        .s_axi_wvalid    (s_axi_wvalid),
        .s_axi_wready    (s_axi_wready),
        .s_axi_bresp     (s_axi_bresp),
        .s_axi_bvalid    (s_axi_bvalid),
        .s_axi_bready    (s_axi_bready),
        .s_axi_araddr    (s_axi_araddr),
        .s_axi_arvalid   (s_axi_arvalid),
        .s_axi_arready   (s_axi_arready),
        .s_axi_rdata     (s_axi_rdata),
        .s_axi_rresp     (s_axi_rresp),
        .s_axi_rvalid    (s_axi_rvalid),
        .s_axi_rready    (s_axi_rready),
        .stop_or_watch   (stop_or_watch),
        .pin_in          (pin_in),
        .pin_out         (pin_out),
        .pin_oe          (pin_oe),
        .pin_pullup_on   (pin_pullup_on),
        .cmp_a_out       (cmp_a_out),
        .cmp_a_out_en    (cmp_a_out_en),
        .cmp_b_out       (cmp_b_out),
        .cmp_b_out_en    (cmp_b_out_en),
        .periph_in       (periph_in),
        .analog_in_en    (analog_in_en),
        .cmp_a_neg_in_en (cmp_a_neg_in_en),
        .cmp_a_pos_in_en (cmp_a_pos_in_en),
        .cmp_b_neg_in_en (cmp_b_neg_in_en),
        .cmp_b_pos_in_en (cmp_b_pos_in_en)
    );
    p3g_pin_model pins (
        .aclk          (aclk),
        .pin_out       (pin_out),
        .pin_oe        (pin_oe),
        .pin_pullup_on (pin_pullup_on),
        .ext_en        (ext_en),
        .ext_val       (ext_val),
        .pin_in        (pin_in)
    );

    initial forever #2.5 aclk = ~aclk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit got;
        got = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                got = 1;
            end
        end
        chk({6'h0, resp}, {6'h0, p3g_pkg::P3G_RESP_OKAY});
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        bit got;
        got = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        while (!got) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                resp = s_axi_rresp;
                s_axi_rready <= 1'h0;
                chk(s_axi_rdata[7:0], e);
                chk(s_axi_rdata[15:8] | s_axi_rdata[23:16] | s_axi_rdata[31:24], 8'h00);
                got = 1;
            end
        end
    endtask

    // Pins settle two sync edges plus two output edges after a change
    task automatic settle();
        repeat (4) @(posedge aclk);
    endtask

    task automatic t_reset();
        settle();
        chk(pin_oe, 8'h00);
        chk(analog_in_en, 8'hFF);
        rdc(`P3G_OFS_DIR, 8'h00);
        rdc(`P3G_OFS_AIN_DIS, 8'h00);
        rdc(8'h1C, 8'h00);
        chk({6'h0, resp}, {6'h0, p3g_pkg::P3G_RESP_SLVERR});
    endtask

    task automatic t_port();
        ext_en <= 8'hFF;
        ext_val <= 8'h5A;
        wr(`P3G_OFS_AIN_DIS, 8'hFF);
        wr(`P3G_OFS_DATA, 8'h3C);
        settle();
        chk(pin_oe, 8'h00);
        rdc(`P3G_OFS_DATA, 8'h5A);
        rdc(`P3G_OFS_DATA_RMW, 8'h3C);
        chk(periph_in, 8'h5A);
        ext_en <= 8'h5A;
        wr(`P3G_OFS_DIR, 8'hA5);
        settle();
        chk(pin_oe, 8'hA5);
        chk(pin_out & 8'hA5, 8'h3C & 8'hA5);
        rdc(`P3G_OFS_DATA, (8'h3C & 8'hA5) | 8'h5A);
        wr(`P3G_OFS_AIN_DIS, 8'h0F);
        settle();
        rdc(`P3G_OFS_DATA, 8'h24 | (8'h5A & 8'h0F));
        rdc(`P3G_OFS_PIN_RAW, 8'h7E);
        chk(periph_in, 8'h7E & 8'h0F);
        chk(analog_in_en, 8'hF0);
        wr(`P3G_OFS_PULLUP, 8'hFF);
        settle();
        chk(pin_pullup_on, ~(8'hA5 & ~8'h3C));
    endtask

    task automatic t_standby();
        stop_or_watch <= 1'h1;
        wr(`P3G_OFS_CTRL, 8'h01);
        settle();
        chk(pin_oe, 8'h00);
        chk(pin_pullup_on, 8'h00);
        chk(periph_in, 8'h00);
        wr(`P3G_OFS_CTRL, 8'h00);
        settle();
        chk(pin_oe, 8'hA5);
        chk(pin_pullup_on, 8'h7E);
        stop_or_watch <= 1'h0;
    endtask

    task automatic t_analog();
        wr(`P3G_OFS_DIR, 8'h00);
        wr(`P3G_OFS_AIN_DIS, 8'h00);
        wr(`P3G_OFS_PULLUP, 8'h00);
        settle();
        chk(analog_in_en, 8'hFF);
        chk(pin_pullup_on, 8'h00);
        s_axi_wstrb <= 4'hE;
        wr(`P3G_OFS_DIR, 8'hFF);
        s_axi_wstrb <= 4'hF;
        rdc(`P3G_OFS_DIR, 8'h00);
    endtask

    task automatic t_cmp();
        wr(`P3G_OFS_AIN_DIS, 8'hFF);
        wr(`P3G_OFS_DIR, 8'h81);
        cmp_a_out_en <= 1'h1;
        cmp_b_out_en <= 1'h1;
        settle();
        chk(pin_oe, 8'hA5);
        chk(pin_out & 8'h24, 8'h00);
        rdc(`P3G_OFS_DATA, 8'h5A);
        rdc(`P3G_OFS_DATA_RMW, 8'h3C);
        cmp_a_out <= 1'h1;
        settle();
        chk(pin_out & 8'h24, 8'h04);
        rdc(`P3G_OFS_DATA, 8'h5E);
        cmp_a_out <= 1'h0;
        cmp_a_out_en <= 1'h0;
        cmp_b_out_en <= 1'h0;
        for (int v = 0; v < 16; v++) begin
            wr(`P3G_OFS_CTRL, 8'(v << 1));
            settle();
            chk({4'h0, cmp_a_pos_in_en, cmp_a_neg_in_en, cmp_b_pos_in_en, cmp_b_neg_in_en},
                {4'h0, !v[0], !v[0] && !v[1], !v[2], !v[2] && !v[3]});
        end
    endtask

    task automatic t_rerun();
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset();
        t_port();
        t_standby();
        t_analog();
        t_cmp();
        t_rerun();
        stop_test();
    end

    // The whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        error_cnt++;
        stop_test();
    end
endmodule

`default_nettype wire
